// >>> core/mac_datapath_pkg.sv
// Package for the extended MAC / ALU / bit manipulation datapath.
// Assumes a single core clock and a decoder that drives one operation per cycle.
package mac_datapath_pkg;
   // Data widths
   localparam int ACC_W = 40;
   localparam int HALF_W = 16;
   localparam int PROD_W = 32;
   // Arithmetic unit control bit positions
   localparam int CTL_W = 16;
   localparam int CTL_FULL_SATURATE_ENABLE_BIT = 10;
   localparam int CTL_P1LSB_BIT = 9;
   localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;
   // Shift amounts used by the mixed and double precision sums
   localparam int SHIFT_P1_MIX = 15;
   localparam int SHIFT_P1_DBL = 16;
   localparam int SHIFT_ACC_DBL = 14;
   // Saturation bounds at 32 bits, sign extended to 40
   localparam logic [ACC_W-1:0] SAT_POS = 40'h007FFFFFFF;
   localparam logic [ACC_W-1:0] SAT_NEG = 40'hFF80000000;
   localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;
   // Multiplier operand select
   typedef enum logic [2:0] {
      MUL_NONE = 3'h0, MUL_HH_LL = 3'h1, MUL_HL_LH = 3'h2, MUL_MIX = 3'h3,
      MUL_DBL_A = 3'h4, MUL_DBL_B = 3'h5, MUL_SQR = 3'h6, MUL_CLR = 3'h7
   } mul_op_t;
   // Arithmetic unit / add-compare-select operations
   typedef enum logic [3:0] {
      AU_NONE = 4'h0, AU_ADD_P0 = 4'h1, AU_SUB_P0 = 4'h2, AU_ADD_AB = 4'h3,
      AU_CMP_A = 4'h4, AU_CMP_B = 4'h5, AU_CMP_C = 4'h6, AU_MIN = 4'h7,
      AU_ABS = 4'h8, AU_RND = 4'h9, AU_SPLIT_ADD = 4'hA, AU_SPLIT_SUB = 4'hB,
      AU_FFT = 4'hC, AU_ADD_Y = 4'hD, AU_SUB_Y = 4'hE
   } au_op_t;
   // Parallel three-input adder operations
   typedef enum logic [2:0] {
      AD_NONE = 3'h0, AD_THREE = 3'h1, AD_MIX = 3'h2, AD_DBL = 3'h3,
      AD_FFT = 3'h4, AD_ADD_B = 3'h5, AD_SUB_B = 3'h6
   } add_op_t;
   // Bit manipulation operations
   typedef enum logic [1:0] {
      BM_NONE = 2'h0, BM_SHR = 2'h1, BM_SHL = 2'h2, BM_EXP = 2'h3
   } bm_op_t;
endpackage

// >>> core/sat_add3.sv
// Three-operand adder with optional 32-bit saturation of partial and final sums.
// Assumes operands already aligned to the 40-bit accumulator format.
`timescale 1ns/1ps
module sat_add3
   import mac_datapath_pkg::*;
(
   // Operands
   input wire logic [ACC_W-1:0] a_i,
   input wire logic [ACC_W-1:0] b_i,
   input wire logic [ACC_W-1:0] c_i,
   // Control
   input wire logic sat_i,
   // Result
   output logic [ACC_W-1:0] sum_o,
   output logic ovf32_o
);
   logic [ACC_W-1:0] part;
   logic [ACC_W-1:0] part_sat;
   logic [ACC_W-1:0] full;

   // Fits in 32 bits when bits 39..31 agree
   function automatic logic fits32(input logic [ACC_W-1:0] v);
      fits32 = (&v[ACC_W-1:PROD_W-1]) | ~(|v[ACC_W-1:PROD_W-1]);
   endfunction

   function automatic logic [ACC_W-1:0] sat32(input logic [ACC_W-1:0] v);
      if (fits32(v)) begin
         sat32 = v;
      end else if (v[ACC_W-1]) begin
         sat32 = SAT_NEG;
      end else begin
         sat32 = SAT_POS;
      end
   endfunction

   // Partial sum saturated before the third operand is applied
   always_comb begin
      part = a_i + b_i;
      part_sat = sat_i ? sat32(part) : part;
      full = part_sat + c_i;
      sum_o = sat_i ? sat32(full) : full;
      ovf32_o = ~fits32(full);
   end
endmodule

// >>> core/mac_datapath.sv
// Extended-format datapath: dual multipliers, arithmetic unit, adder, bit manip unit.
// Assumes a decoder supplies operation codes and operands each cycle, synchronous to sys_clk_i.
`timescale 1ns/1ps
// What this block does
// - Arithmetic unit or compare-select ops set flags; split mode leaves them alone unless an adder op runs, which sets them.
// - Without arithmetic unit op, the adder or bit manip op sets the flags.
// - With full saturate set, three-input sums saturate partial and final results.
// - Control bit 9 clears the low bit of the second product shifted by 15.
// - Bit manip op runs alone or alongside an arithmetic unit op.
// - Transform op: high and low products added to negated pair accumulators.
// - Compare-select picks a value into destination, adder may update partner.
// - Minimum select runs with exponent into partner accumulator high half.
// - Mixed precision products are 16 bits by 31 bits.
// - Double precision products are 31 by 31, built over several steps.
module mac_datapath
   import mac_datapath_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Operation selects from the decoder
   input wire mul_op_t mul_op_i,
   input wire au_op_t au_op_i,
   input wire add_op_t add_op_i,
   input wire bm_op_t bm_op_i,
   // Control register write
   input wire logic ctl_we_i,
   input wire logic [CTL_W-1:0] ctl_wdata_i,
   // Operands
   input wire logic [2*HALF_W-1:0] x_i,
   input wire logic [2*HALF_W-1:0] y_i,
   input wire logic [ACC_W-1:0] src_a_i,
   input wire logic [ACC_W-1:0] src_b_i,
   input wire logic [ACC_W-1:0] pair_a_i,
   input wire logic [ACC_W-1:0] pair_b_i,
   input wire logic [5:0] shift_i,
   // Results
   output logic [ACC_W-1:0] dest_o,
   output logic dest_we_o,
   output logic [ACC_W-1:0] pair_o,
   output logic pair_we_o,
   output logic pair_high_only_o,
   output logic [2*HALF_W-1:0] x_o,
   output logic x_we_o,
   output logic [PROD_W-1:0] first_product_o,
   output logic [PROD_W-1:0] second_product_o,
   output logic [CTL_W-1:0] arith_unit_control_0_o,
   // Condition flags
   output logic flag_neg_o,
   output logic flag_zero_o,
   output logic flag_ovf40_o,
   output logic flag_ovf32_o
);
   logic [CTL_W-1:0] ctl_reg;
   logic [PROD_W-1:0] first_product_reg, second_product_reg;
   logic [PROD_W-1:0] first_product_next, second_product_next;
   logic [ACC_W-1:0] dest_reg, dest_next, pair_reg, pair_next;
   logic dest_we_reg, dest_we_next, pair_we_reg, pair_we_next, pair_hi_reg, pair_hi_next;
   logic [2*HALF_W-1:0] x_reg, x_next;
   logic x_we_reg, x_we_next;
   logic neg_reg, zero_reg, ovf40_reg, ovf32_reg;
   logic flag_upd, flag_ovf32;
   logic [ACC_W-1:0] flag_val;
   logic flag_ovf40;
   logic [ACC_W-1:0] p0x, p1x, p1_mix, p1_dbl, p0_half, add_a, add_b, add_c, add_sum;
   logic add_ovf32;
   logic [ACC_W-1:0] bm_res;
   logic [ACC_W:0] au_wide;
   logic signed [HALF_W:0] ma0, mb0, ma1, mb1;
   logic signed [2*HALF_W+1:0] m0, m1;

   wire full_saturate_enable = ctl_reg[CTL_FULL_SATURATE_ENABLE_BIT];
   wire p1lsb_clr = ctl_reg[CTL_P1LSB_BIT];
   wire signed [HALF_W:0] xh = {x_i[2*HALF_W-1], x_i[2*HALF_W-1:HALF_W]};
   wire signed [HALF_W:0] xl_s = {x_i[HALF_W-1], x_i[HALF_W-1:0]};
   wire signed [HALF_W:0] yh = {y_i[2*HALF_W-1], y_i[2*HALF_W-1:HALF_W]};
   wire signed [HALF_W:0] yl_s = {y_i[HALF_W-1], y_i[HALF_W-1:0]};
   // Logical one-bit right shift of a low half, so it acts as a positive 15-bit value
   wire signed [HALF_W:0] xl_lsr = {2'b00, x_i[HALF_W-1:1]};
   wire signed [HALF_W:0] yl_lsr = {2'b00, y_i[HALF_W-1:1]};

   ////////////////////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_reg <= CTL_RESET;
      end else if (ctl_we_i) begin
         ctl_reg <= ctl_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Multiplier operand selection; 17-bit signed operands hold both signed halves
   // and the shifted low halves that form the 31-bit precision products
   always_comb begin
      ma0 = xh;
      mb0 = yh;
      ma1 = xl_s;
      mb1 = yl_s;
      unique case (mul_op_i)
         MUL_HL_LH: begin
            mb0 = yl_s;
            mb1 = yh;
         end
         MUL_MIX: begin
            ma1 = xh;
            mb1 = yl_lsr;
         end
         MUL_DBL_A: begin
            ma0 = xl_lsr;
            ma1 = xh;
            mb1 = yh;
         end
         MUL_DBL_B: begin
            mb0 = yl_lsr;
            ma1 = xl_lsr;
            mb1 = yl_lsr;
         end
         MUL_SQR: begin
            mb0 = xh;
            mb1 = xl_s;
         end
         MUL_NONE, MUL_HH_LL, MUL_CLR: begin
         end
      endcase
      m0 = ma0 * mb0;
      m1 = ma1 * mb1;
   end

   // Product registers load in a single cycle
   always_comb begin
      first_product_next = first_product_reg;
      second_product_next = second_product_reg;
      if (mul_op_i == MUL_CLR) begin
         first_product_next = '0;
         second_product_next = '0;
      end else if (mul_op_i != MUL_NONE) begin
         first_product_next = m0[PROD_W-1:0];
         second_product_next = m1[PROD_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         first_product_reg <= '0;
         second_product_reg <= '0;
      end else begin
         first_product_reg <= first_product_next;
         second_product_reg <= second_product_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Three-input adder operands built from the current product registers and the accumulator inputs
   always_comb begin
      p0x = {{(ACC_W-PROD_W){first_product_reg[PROD_W-1]}}, first_product_reg};
      p1x = {{(ACC_W-PROD_W){second_product_reg[PROD_W-1]}}, second_product_reg};
      p1_mix = $signed(p1x) >>> SHIFT_P1_MIX;
      if (p1lsb_clr) begin
         p1_mix[0] = 1'b0;
      end
      p1_dbl = $signed(p1x) >>> SHIFT_P1_DBL;
      p0_half = $signed(p0x) >>> 1;
      add_a = '0;
      add_b = '0;
      add_c = '0;
      unique case (add_op_i)
         AD_THREE: begin
            add_a = src_a_i;
            add_b = p0x;
            add_c = p1x;
         end
         AD_MIX: begin
            add_b = p0x;
            add_c = p1_mix;
         end
         AD_DBL: begin
            add_b = p0_half;
            add_c = p1_dbl;
         end
         AD_FFT: begin
            add_a = -pair_a_i;
            add_b = p1x;
         end
         AD_ADD_B: begin
            add_a = pair_a_i;
            add_b = pair_b_i;
         end
         AD_SUB_B: begin
            add_a = pair_a_i;
            add_b = -pair_b_i;
         end
         AD_NONE: begin
         end
      endcase
   end

   sat_add3 u_add (
      .a_i(add_a),
      .b_i(add_b),
      .c_i(add_c),
      .sat_i(full_saturate_enable & (add_op_i == AD_THREE)),
      .sum_o(add_sum),
      .ovf32_o(add_ovf32)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bit manipulation unit: shifts and exponent, independent of the arithmetic unit
   always_comb begin
      bm_res = '0;
      unique case (bm_op_i)
         BM_SHR: bm_res = $signed(src_b_i) >>> shift_i;
         BM_SHL: bm_res = src_b_i << shift_i;
         BM_EXP: begin
            // Redundant sign bits: the highest bit that differs from the sign wins,
            // so a zero count from bit 38 is not mistaken for no hit
            bm_res = ACC_W'(ACC_W - 1);
            for (int i = 0; i <= ACC_W-2; i++) begin
               if (src_b_i[i] != src_b_i[ACC_W-1]) begin
                  bm_res = ACC_W'(ACC_W - 2 - i);
               end
            end
         end
         BM_NONE: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Arithmetic unit / compare-select and write-back routing
   always_comb begin
      au_wide = '0;
      x_next = x_reg;
      x_we_next = 1'b0;
      dest_next = dest_reg;
      dest_we_next = 1'b0;
      pair_next = pair_reg;
      pair_we_next = 1'b0;
      pair_hi_next = 1'b0;
      unique case (au_op_i)
         AU_ADD_P0: au_wide = {src_a_i[ACC_W-1], src_a_i} + {p0x[ACC_W-1], p0x};
         AU_SUB_P0: au_wide = {src_a_i[ACC_W-1], src_a_i} - {p0x[ACC_W-1], p0x};
         AU_ADD_AB: au_wide = {src_a_i[ACC_W-1], src_a_i} + {src_b_i[ACC_W-1], src_b_i};
         AU_ADD_Y: au_wide = {src_a_i[ACC_W-1], src_a_i} + (ACC_W+1)'($signed(y_i));
         AU_SUB_Y: au_wide = {src_a_i[ACC_W-1], src_a_i} - (ACC_W+1)'($signed(y_i));
         AU_FFT: au_wide = {p0x[ACC_W-1], p0x} - {src_a_i[ACC_W-1], src_a_i};
         // Compare variants: larger, larger-or-equal, smaller of the two
         AU_CMP_A: au_wide = ($signed(src_a_i) > $signed(src_b_i)) ?
            {src_a_i[ACC_W-1], src_a_i} : {src_b_i[ACC_W-1], src_b_i};
         AU_CMP_B: au_wide = ($signed(src_a_i) >= $signed(src_b_i)) ?
            {src_a_i[ACC_W-1], src_a_i} : {src_b_i[ACC_W-1], src_b_i};
         AU_CMP_C, AU_MIN: au_wide = ($signed(src_a_i) < $signed(src_b_i)) ?
            {src_a_i[ACC_W-1], src_a_i} : {src_b_i[ACC_W-1], src_b_i};
         AU_ABS: au_wide = src_a_i[ACC_W-1] ? -{1'b1, src_a_i} : {1'b0, src_a_i};
         AU_RND: au_wide = {src_a_i[ACC_W-1], src_a_i} + (ACC_W+1)'(41'h0000008000) &
            ~(ACC_W+1)'(41'h000000FFFF);
         AU_SPLIT_ADD: begin
            x_next = {16'(src_a_i[2*HALF_W-1:HALF_W] + y_i[2*HALF_W-1:HALF_W]),
               16'(src_a_i[HALF_W-1:0] + y_i[HALF_W-1:0])};
            x_we_next = 1'b1;
         end
         AU_SPLIT_SUB: begin
            x_next = {16'(src_a_i[2*HALF_W-1:HALF_W] - y_i[2*HALF_W-1:HALF_W]),
               16'(src_a_i[HALF_W-1:0] - y_i[HALF_W-1:0])};
            x_we_next = 1'b1;
         end
         AU_NONE: begin
         end
      endcase
      if (au_op_i != AU_NONE && !x_we_next) begin
         dest_next = au_wide[ACC_W-1:0];
         dest_we_next = 1'b1;
      end
      // Adder writes partner, or destination when no arithmetic unit op or a split op runs
      if (add_op_i != AD_NONE) begin
         if (au_op_i == AU_NONE || x_we_next) begin
            dest_next = add_sum;
            dest_we_next = 1'b1;
         end else begin
            pair_next = add_sum;
            pair_we_next = 1'b1;
         end
      end else if (bm_op_i != BM_NONE) begin
         pair_next = bm_res;
         pair_we_next = 1'b1;
         pair_hi_next = (bm_op_i == BM_EXP);
         if (au_op_i == AU_NONE) begin
            dest_next = bm_res;
            dest_we_next = 1'b1;
            pair_we_next = 1'b0;
            pair_hi_next = 1'b0;
         end
      end
   end

   // Flag source selection: non-split arithmetic unit op first, then adder, then bit manip only when no arithmetic unit op runs
   always_comb begin
      flag_upd = 1'b1;
      flag_val = bm_res;
      flag_ovf40 = 1'b0;
      flag_ovf32 = 1'b0;
      if (au_op_i == AU_SPLIT_ADD || au_op_i == AU_SPLIT_SUB) begin
         flag_upd = (add_op_i != AD_NONE);
         flag_val = add_sum;
         flag_ovf32 = add_ovf32;
      end else if (au_op_i != AU_NONE) begin
         flag_val = au_wide[ACC_W-1:0];
         flag_ovf40 = au_wide[ACC_W] ^ au_wide[ACC_W-1];
         flag_ovf32 = ~((&au_wide[ACC_W-1:PROD_W-1]) | ~(|au_wide[ACC_W-1:PROD_W-1]));
      end else if (add_op_i != AD_NONE) begin
         flag_val = add_sum;
         flag_ovf32 = add_ovf32;
      end else begin
         flag_upd = (bm_op_i != BM_NONE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result and flag registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dest_reg <= ACC_RESET;
         dest_we_reg <= 1'b0;
         pair_reg <= ACC_RESET;
         pair_we_reg <= 1'b0;
         pair_hi_reg <= 1'b0;
         x_reg <= '0;
         x_we_reg <= 1'b0;
      end else begin
         dest_reg <= dest_next;
         dest_we_reg <= dest_we_next;
         pair_reg <= pair_next;
         pair_we_reg <= pair_we_next;
         pair_hi_reg <= pair_hi_next;
         x_reg <= x_next;
         x_we_reg <= x_we_next;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         neg_reg <= 1'b0;
         zero_reg <= 1'b0;
         ovf40_reg <= 1'b0;
         ovf32_reg <= 1'b0;
      end else if (flag_upd) begin
         neg_reg <= flag_val[ACC_W-1];
         zero_reg <= (flag_val == '0);
         ovf40_reg <= flag_ovf40;
         ovf32_reg <= flag_ovf32;
      end
   end

   // Outputs straight from flip-flops
   assign dest_o = dest_reg;
   assign dest_we_o = dest_we_reg;
   assign pair_o = pair_reg;
   assign pair_we_o = pair_we_reg;
   assign pair_high_only_o = pair_hi_reg;
   assign x_o = x_reg;
   assign x_we_o = x_we_reg;
   assign first_product_o = first_product_reg;
   assign second_product_o = second_product_reg;
   assign arith_unit_control_0_o = ctl_reg;
   assign flag_neg_o = neg_reg;
   assign flag_zero_o = zero_reg;
   assign flag_ovf40_o = ovf40_reg;
   assign flag_ovf32_o = ovf32_reg;
endmodule

// >>> test/mac_datapath_chk.sv
// Concurrent checks on the extended MAC datapath ports.
// Assumes one core clock and an active high asynchronous reset.
`timescale 1ns/1ps
module mac_datapath_chk
   import mac_datapath_pkg::*;
(
   // Clock, reset and operation selects
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire mul_op_t mul_op_i,
   input wire au_op_t au_op_i,
   input wire add_op_t add_op_i,
   input wire bm_op_t bm_op_i,
   // Operands
   input wire logic [2*HALF_W-1:0] x_i,
   input wire logic [2*HALF_W-1:0] y_i,
   // Results
   input wire logic [ACC_W-1:0] dest_o,
   input wire logic dest_we_o,
   input wire logic pair_we_o,
   input wire logic pair_high_only_o,
   input wire logic x_we_o,
   input wire logic [PROD_W-1:0] first_product_o,
   input wire logic [PROD_W-1:0] second_product_o,
   input wire logic [CTL_W-1:0] arith_unit_control_0_o,
   input wire logic flag_neg_o,
   input wire logic flag_zero_o,
   input wire logic flag_ovf40_o,
   input wire logic flag_ovf32_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Multi-unit operation sets
   sequence s_split;
      (au_op_i == AU_SPLIT_ADD || au_op_i == AU_SPLIT_SUB) && add_op_i == AD_NONE;
   endsequence
   sequence s_fft;
      au_op_i == AU_FFT && add_op_i == AD_FFT;
   endsequence
   sequence s_min_exp;
      au_op_i == AU_MIN && bm_op_i == BM_EXP;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_SPLIT_FLAGS: assert property (s_split |=> x_we_o &&
      $stable({flag_neg_o, flag_zero_o, flag_ovf40_o, flag_ovf32_o}))
      else $error("split op changed flags");
   AST_NOAU_FLAGS: assert property (dest_we_o && $past(au_op_i) == AU_NONE |->
      flag_zero_o == (dest_o == '0) && flag_neg_o == dest_o[ACC_W-1])
      else $error("flags do not follow adder or shifter result");
   AST_IDLE: assert property (au_op_i == AU_NONE && add_op_i == AD_NONE &&
      bm_op_i == BM_NONE && mul_op_i != MUL_CLR |=> !dest_we_o && !pair_we_o && !x_we_o)
      else $error("write strobe without operation");
   AST_PROD: assert property (mul_op_i == MUL_HH_LL |=>
      $signed(first_product_o) == $signed($past(x_i[31:16])) * $signed($past(y_i[31:16]))
      && $signed(second_product_o) == $signed($past(x_i[15:0])) * $signed($past(y_i[15:0])))
      else $error("product registers wrong");
   AST_FFT: assert property (s_fft |=> dest_we_o && pair_we_o)
      else $error("transform op did not write both accumulators");
   AST_MIN_EXP: assert property (s_min_exp |=> dest_we_o && pair_we_o && pair_high_only_o)
      else $error("minimum with exponent writes wrong");
   AST_SAT: assert property (add_op_i == AD_THREE && au_op_i == AU_NONE &&
      arith_unit_control_0_o[CTL_FULL_SATURATE_ENABLE_BIT] |=> $signed(dest_o) <= $signed(SAT_POS)
      && $signed(dest_o) >= $signed(SAT_NEG))
      else $error("saturated sum out of 32-bit range");
   AST_MIX_LSB: assert property (add_op_i == AD_MIX && au_op_i == AU_NONE &&
      arith_unit_control_0_o[CTL_P1LSB_BIT] |=> dest_o[0] == $past(first_product_o[0]))
      else $error("shifted second product low bit not cleared");
endmodule

bind mac_datapath mac_datapath_chk chk (.*);

// >>> test/test_mac_datapath.sv
// Self-checking bench for the extended MAC datapath.
// Assumes results one cycle after the op edge; inputs change at falling edges.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   $display("wrong value %s exp %0h got %0h", n, e, g); errors++; end end
module test_mac_datapath
   import mac_datapath_pkg::*;
;
   logic sys_clk_i = 0, rst_i = 1, ctl_we = 0, dest_we, pair_we, pair_hi, x_we;
   logic fneg, fzero, fovf40, fovf32;
   mul_op_t mul_op = MUL_NONE;
   au_op_t au_op = AU_NONE;
   add_op_t add_op = AD_NONE;
   bm_op_t bm_op = BM_NONE;
   logic [15:0] ctl_wdata = 16'h0000, ctl;
   logic [31:0] x = 32'h0, y = 32'h0, x_out, p0, p1;
   logic [39:0] src_a = 40'h0, src_b = 40'h0, pair_a = 40'h0, pair_b = 40'h0, dest, pair;
   logic [5:0] shift = 6'h1;
   int errors = 0, checks_done = 0, cycles = 0;
   mac_datapath dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mul_op_i(mul_op),
      .au_op_i(au_op), .add_op_i(add_op), .bm_op_i(bm_op), .ctl_we_i(ctl_we),
      .ctl_wdata_i(ctl_wdata), .x_i(x), .y_i(y), .src_a_i(src_a), .src_b_i(src_b),
      .pair_a_i(pair_a), .pair_b_i(pair_b), .shift_i(shift), .dest_o(dest),
      .dest_we_o(dest_we), .pair_o(pair), .pair_we_o(pair_we), .pair_high_only_o(pair_hi),
      .x_o(x_out), .x_we_o(x_we), .first_product_o(p0), .second_product_o(p1),
      .arith_unit_control_0_o(ctl), .flag_neg_o(fneg), .flag_zero_o(fzero),
      .flag_ovf40_o(fovf40), .flag_ovf32_o(fovf32));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_of_test();
      if (errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One op set for one rising edge; it stands until the next op or control write
   task automatic op(input mul_op_t m, input au_op_t a, input add_op_t d, input bm_op_t b);
      mul_op = m;
      au_op = a;
      add_op = d;
      bm_op = b;
      @(negedge sys_clk_i);
   endtask
   // Control register write, with the operation selects idle
   task automatic wctl(input logic [15:0] v);
      mul_op = MUL_NONE;
      au_op = AU_NONE;
      add_op = AD_NONE;
      bm_op = BM_NONE;
      ctl_wdata = v;
      ctl_we = 1;
      @(negedge sys_clk_i);
      ctl_we = 0;
      `CHK("ctl", v, ctl)
   endtask
   // Accumulator operands in one go
   task automatic accs(input logic [39:0] a, b, pa, pb);
      src_a = a;
      src_b = b;
      pair_a = pa;
      pair_b = pb;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_mul_add();
      x = 32'h80000003;
      y = 32'h80000005;
      op(MUL_HH_LL, AU_NONE, AD_NONE, BM_NONE);
      `CHK("p0", 32'h40000000, p0)
      `CHK("p1", 32'h0000000F, p1)
      accs(40'h10, 40'h0, 40'h0, 40'h0);
      op(MUL_NONE, AU_NONE, AD_THREE, BM_NONE);
      `CHK("dest", 40'h004000001F, dest)
      `CHK("fzero", 1'h0, fzero)
   endtask
   task automatic t_full_saturate_enable();
      wctl(16'h0000);
      x = 32'h80008000;
      y = 32'h80008000;
      op(MUL_HH_LL, AU_NONE, AD_NONE, BM_NONE);
      accs(40'h007F000000, 40'h0, 40'h0, 40'h0);
      op(MUL_NONE, AU_NONE, AD_THREE, BM_NONE);
      `CHK("dest", 40'h00FF000000, dest)
      `CHK("fovf32", 1'h1, fovf32)
      wctl(16'h0400);
      op(MUL_NONE, AU_NONE, AD_THREE, BM_NONE);
      `CHK("dest", 40'h007FFFFFFF, dest)
      // Negative third operand shows that the partial sum was clamped first
      y = 32'h80007FFF;
      op(MUL_HH_LL, AU_NONE, AD_NONE, BM_NONE);
      op(MUL_NONE, AU_NONE, AD_THREE, BM_NONE);
      `CHK("dest", 40'h0040007FFF, dest)
   endtask
   task automatic t_mix();
      wctl(16'h0000);
      x = 32'h00020000;
      y = 32'h00008000;
      op(MUL_MIX, AU_NONE, AD_NONE, BM_NONE);
      `CHK("p1", 32'h00008000, p1)
      op(MUL_NONE, AU_NONE, AD_MIX, BM_NONE);
      `CHK("dest", 40'h1, dest)
      wctl(16'h0200);
      op(MUL_NONE, AU_NONE, AD_MIX, BM_NONE);
      `CHK("dest", 40'h0, dest)
   endtask
   task automatic t_dbl();
      x = 32'h01008000;
      y = 32'h01000000;
      op(MUL_DBL_A, AU_NONE, AD_NONE, BM_NONE);
      `CHK("p0", 32'h00400000, p0)
      op(MUL_NONE, AU_NONE, AD_DBL, BM_NONE);
      `CHK("dest", 40'h0000200001, dest)
   endtask
   task automatic t_fft();
      x = 32'h00020003;
      y = 32'h00040005;
      op(MUL_HH_LL, AU_NONE, AD_NONE, BM_NONE);
      accs(40'h1, 40'h5, 40'h5, 40'h5);
      op(MUL_NONE, AU_FFT, AD_FFT, BM_NONE);
      `CHK("dest", 40'h7, dest)
      `CHK("pair", 40'hA, pair)
   endtask
   task automatic t_split();
      wctl(16'h0000);
      accs(40'hFF00000000, 40'h0, 40'h0, 40'h0);
      op(MUL_NONE, AU_NONE, AD_THREE, BM_NONE);
      `CHK("fneg", 1'h1, fneg)
      accs(40'h00010002, 40'h0, 40'h0, 40'h0);
      op(MUL_NONE, AU_SPLIT_ADD, AD_NONE, BM_NONE);
      `CHK("x_we", 1'h1, x_we)
      `CHK("x_out", 32'h00050007, x_out)
      `CHK("fneg", 1'h1, fneg)
   endtask
   task automatic t_cmp();
      accs(40'h7FFFFFFFFF, 40'h1, 40'h0, 40'h0);
      op(MUL_NONE, AU_ADD_AB, AD_NONE, BM_NONE);
      `CHK("dest", 40'h8000000000, dest)
      `CHK("fovf40", 1'h1, fovf40)
      accs(40'h7, 40'h2, 40'h9, 40'h2);
      op(MUL_NONE, AU_CMP_A, AD_ADD_B, BM_NONE);
      `CHK("dest", 40'h7, dest)
      `CHK("pair", 40'hB, pair)
      op(MUL_NONE, AU_CMP_B, AD_NONE, BM_NONE);
      `CHK("dest", 40'h7, dest)
      `CHK("fovf40", 1'h0, fovf40)
      op(MUL_NONE, AU_CMP_C, AD_SUB_B, BM_NONE);
      `CHK("dest", 40'h2, dest)
      `CHK("pair", 40'h7, pair)
   endtask
   task automatic t_min_exp();
      accs(40'h5, 40'h3, 40'h3, 40'h3);
      op(MUL_NONE, AU_MIN, AD_NONE, BM_EXP);
      `CHK("dest", 40'h3, dest)
      `CHK("pair", 40'h25, pair)
      `CHK("pair_we", 1'h1, pair_we)
      `CHK("pair_hi", 1'h1, pair_hi)
      accs(40'h5, 40'h6000000000, 40'h0, 40'h0);
      op(MUL_NONE, AU_MIN, AD_NONE, BM_EXP);
      `CHK("dest", 40'h5, dest)
      `CHK("pair", 40'h0, pair)
   endtask
   task automatic t_bmu();
      accs(40'h0, 40'h3, 40'h0, 40'h0);
      op(MUL_NONE, AU_NONE, AD_NONE, BM_SHL);
      `CHK("dest", 40'h6, dest)
      accs(40'h0, 40'h0, 40'h0, 40'h0);
      op(MUL_NONE, AU_NONE, AD_NONE, BM_SHL);
      `CHK("dest_we", 1'h1, dest_we)
      `CHK("fzero", 1'h1, fzero)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(negedge sys_clk_i);
      rst_i = 0;
      @(negedge sys_clk_i);
      `CHK("dest", 40'h0, dest)
      `CHK("ctl", 16'h0000, ctl)
      t_mul_add();
      t_full_saturate_enable();
      t_mix();
      t_dbl();
      t_fft();
      t_split();
      t_cmp();
      t_min_exp();
      t_bmu();
      end_of_test();
   end
endmodule
